// file: core/asbd_pkg.sv
// constants, field layouts and state types of the serial status and baud block
package asbd_pkg;

   localparam logic [7:0] OFS_STATUS_ONE = 8'h10;
   localparam logic [7:0] OFS_STATUS_TWO = 8'h14;
   localparam logic [7:0] OFS_DATA       = 8'h18;
   localparam logic [7:0] OFS_BAUD       = 8'h1C;
   localparam logic [7:0] OFS_CTRL       = 8'h20;
   localparam logic [7:0] OFS_IRQ_EN     = 8'h24;

   localparam logic [3:0] TICK_LAST      = 4'hF;
   localparam logic [3:0] SAMPLE_A       = 4'h7;
   localparam logic [3:0] SAMPLE_B       = 4'h8;
   localparam logic [3:0] SAMPLE_C       = 4'h9;
   localparam logic [3:0] FRAME_BITS_8   = 4'hA;
   localparam logic [3:0] FRAME_BITS_9   = 4'hB;

   typedef struct packed {
      logic tx_empty_flag;
      logic transmit_done_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_error_flag;
      logic parity_error_flag;
   } asbd_stat_t;

   typedef struct packed {
      logic tx_empty_irq_enable;
      logic transmit_done_irq_enable;
      logic rx_full_irq_enable;
      logic idle_line_irq_enable;
      logic overrun_irq_enable;
      logic noise_irq_enable;
      logic framing_irq_enable;
      logic parity_irq_enable;
   } asbd_irq_en_t;

   typedef struct packed {
      logic       rx_ninth_bit;
      logic       tx_ninth_bit;
      logic       send_break;
      logic       parity_odd;
      logic       parity_enable;
      logic       nine_bit_mode;
      logic       rx_enable;
      logic       tx_enable;
   } asbd_ctrl_t;

   typedef struct packed {
      logic       rsvd_hi;
      logic       lin_break_filter_select;
      logic [1:0] baud_prescale_select;
      logic       rsvd_lo;
      logic [2:0] baud_divisor_select;
   } asbd_baud_t;

   localparam asbd_stat_t   STAT_RESET   = 8'hC0;
   localparam asbd_ctrl_t   CTRL_RESET   = 8'h00;
   localparam asbd_baud_t   BAUD_RESET   = 8'h00;
   localparam asbd_irq_en_t IRQ_EN_RESET = 8'h00;

   typedef enum logic [2:0] {
      RX_IDLE  = 3'b000,
      RX_START = 3'b001,
      RX_DATA  = 3'b010,
      RX_STOP  = 3'b011,
      RX_LIN   = 3'b100
   } asbd_rx_state_t;

   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_PRE   = 2'b01,
      TX_FRAME = 2'b10,
      TX_BRK   = 2'b11
   } asbd_tx_state_t;

endpackage

// file: core/asbd_top.sv
// serial port status flags, data buffer, baud generator, receiver and transmitter
module asbd_top
(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   // apb slave
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // serial pins
   input  wire logic        i_rxd,
   output logic             o_txd,
   // interrupt requests
   output logic             o_tx_irq,
   output logic             o_rx_irq,
   output logic             o_err_irq
);
   import asbd_pkg::*;

   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction

   function automatic logic [3:0] pre_divisor(input logic [1:0] sel);
      case (sel)
         2'h0:    pre_divisor = 4'h1;
         2'h1:    pre_divisor = 4'h3;
         2'h2:    pre_divisor = 4'h4;
         default: pre_divisor = 4'hD;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // registers and bus
   asbd_stat_t     stat_ff;
   asbd_ctrl_t     ctrl_ff;
   asbd_baud_t     baud_ff;
   asbd_irq_en_t   ien_ff;
   logic           bkf_ff;
   logic           rpf_ff;
   logic [7:0]     rx_buf_ff;
   logic [7:0]     tx_buf_ff;
   logic [7:0]     s1_seen_ff;
   logic           s2_seen_ff;
   logic           r8_ff;

   wire access    = i_psel & i_penable & o_pready;
   wire wr_en     = access & i_pwrite;
   wire rd_en     = access & ~i_pwrite;
   wire sel_s1    = (i_paddr == OFS_STATUS_ONE);
   wire sel_s2    = (i_paddr == OFS_STATUS_TWO);
   wire sel_data  = (i_paddr == OFS_DATA);
   wire sel_baud  = (i_paddr == OFS_BAUD);
   wire sel_ctrl  = (i_paddr == OFS_CTRL);
   wire sel_ien   = (i_paddr == OFS_IRQ_EN);
   wire mapped    = sel_s1 | sel_s2 | sel_data | sel_baud | sel_ctrl | sel_ien;
   wire data_rd   = rd_en & sel_data;
   wire data_wr   = wr_en & sel_data;

   // rx flags clear only if the status-1 read showed them set; noise clears after any status-1 read
   wire [7:0] rx_clr = data_rd ? (s1_seen_ff & 8'h3F) : 8'h00;
   wire       te_clr = data_wr & s1_seen_ff[7];
   wire       bk_clr = data_rd & s2_seen_ff;

   logic [31:0] rd_mux;
   assign rd_mux = sel_s1   ? {24'h000000, stat_ff} :
                   sel_s2   ? {30'h00000000, bkf_ff, rpf_ff} :
                   sel_data ? {24'h000000, rx_buf_ff} :
                   sel_baud ? {24'h000000, baud_ff} :
                   sel_ctrl ? {24'h000000, r8_ff, ctrl_ff[6:0]} :
                   sel_ien  ? {24'h000000, ien_ff} : 32'h00000000;

   // zero wait: pready rises in every access phase
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h00000000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready  <= i_psel & ~i_penable;
         o_prdata  <= (i_psel & ~i_penable & ~i_pwrite) ? rd_mux : 32'h00000000;
         o_pslverr <= i_psel & ~i_penable & ~mapped;
      end
   end

   // receive data and ninth bit are not reset
   logic rx_done;
   logic rx_take;
   logic [7:0] rx_char;
   logic       rx_r8;
   always_ff @(posedge i_clock)
   begin
      if (rx_take)
      begin
         rx_buf_ff <= rx_char;
      end
      if (data_wr)
      begin
         tx_buf_ff <= i_pwdata[7:0];
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (rx_take)
      begin
         r8_ff <= rx_r8;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         ctrl_ff    <= CTRL_RESET;
         baud_ff    <= BAUD_RESET;
         ien_ff     <= IRQ_EN_RESET;
         s1_seen_ff <= 8'h00;
         s2_seen_ff <= 1'b0;
      end
      else
      begin
         if (wr_en & sel_ctrl)
         begin
            // bit 7 reads back the received ninth bit, so its store stays zero
            ctrl_ff <= i_pwdata[7:0] & 8'h7F;
         end
         if (wr_en & sel_baud)
         begin
            baud_ff <= i_pwdata[7:0] & 8'h77;
         end
         if (wr_en & sel_ien)
         begin
            ien_ff <= i_pwdata[7:0];
         end
         if (rd_en & sel_s1)
         begin
            s1_seen_ff <= o_prdata[7:0] | 8'h04;
         end
         else if (data_rd | data_wr)
         begin
            s1_seen_ff <= 8'h00;
         end
         if (rd_en & sel_s2)
         begin
            s2_seen_ff <= o_prdata[1];
         end
         else if (data_rd)
         begin
            s2_seen_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // baud tick: prescale then power-of-two divide
   logic [3:0] pre_cnt_ff;
   logic [6:0] div_cnt_ff;
   wire [3:0] pre_last = pre_divisor(baud_ff.baud_prescale_select) - 4'h1;
   wire [6:0] div_mask = 7'((8'h01 << baud_ff.baud_divisor_select) - 8'h01);
   wire       pre_tick = (pre_cnt_ff >= pre_last);
   wire       tick     = pre_tick & ((div_cnt_ff & div_mask) == div_mask);

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         pre_cnt_ff <= 4'h0;
         div_cnt_ff <= 7'h00;
      end
      else
      begin
         pre_cnt_ff <= pre_tick ? 4'h0 : pre_cnt_ff + 4'h1;
         if (tick)
         begin
            div_cnt_ff <= 7'h00;
         end
         else if (pre_tick)
         begin
            div_cnt_ff <= div_cnt_ff + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver: three samples mid-bit, majority vote
   asbd_rx_state_t rx_state_ff;
   logic [3:0] rx_phase_ff;
   logic [3:0] rx_cnt_ff;
   logic [1:0] rx_samp_ff;
   logic [8:0] rx_shift_ff;
   logic       rx_noise_ff;
   logic       rx_one_ff;
   logic       line_high_ff;
   logic       idle_arm_ff;
   logic [7:0] idle_cnt_ff;

   wire [2:0] samples  = {rx_samp_ff, i_rxd};
   wire       bit_val  = maj3(samples);
   wire       bit_nz   = (samples != 3'h0) & (samples != 3'h7);
   wire       decide   = tick & (rx_phase_ff == SAMPLE_C) & (rx_state_ff != RX_IDLE);
   wire       nine     = ctrl_ff.nine_bit_mode;
   wire [3:0] data_lst = nine ? 4'h8 : 4'h7;
   wire [7:0] idle_len = nine ? {FRAME_BITS_9, 4'h0} : {FRAME_BITS_8, 4'h0};
   wire       start    = tick & ~i_rxd & line_high_ff & ctrl_ff.rx_enable;
   wire       is_brk   = ~rx_one_ff & ~bit_val;
   wire       stop_end = decide & (rx_state_ff == RX_STOP) & ~(is_brk & baud_ff.lin_break_filter_select);
   wire       lin_end  = decide & (rx_state_ff == RX_LIN);
   // lin mode: a break must stay low one bit past the stop slot
   wire       brk_det  = (stop_end & is_brk) | (lin_end & ~bit_val);
   wire       fe_det   = (stop_end & ~bit_val) | lin_end;
   wire [8:0] frame9   = nine ? rx_shift_ff : {rx_shift_ff[8], rx_shift_ff[8:1]};
   wire       par_bad  = ctrl_ff.parity_enable & ((^frame9[8:0] ^ (nine ? 1'b0 : frame9[8]))
                         != ctrl_ff.parity_odd);
   wire       idle_hit = ctrl_ff.rx_enable & (rx_state_ff == RX_IDLE) & tick & i_rxd
                         & (idle_cnt_ff == idle_len - 8'h01);

   assign rx_done = stop_end | lin_end;
   assign rx_take = rx_done & ~(stat_ff.rx_full_flag & ~rx_clr[5]);
   assign rx_char = brk_det ? 8'h00 : frame9[7:0];
   assign rx_r8   = brk_det ? 1'b0 : frame9[8];

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rx_state_ff  <= RX_IDLE;
         rx_phase_ff  <= 4'h0;
         rx_cnt_ff    <= 4'h0;
         rx_samp_ff   <= 2'h0;
         rx_shift_ff  <= 9'h000;
         rx_noise_ff  <= 1'b0;
         rx_one_ff    <= 1'b0;
         line_high_ff <= 1'b0;
         idle_cnt_ff  <= 8'h00;
      end
      else
      begin
         if (tick & i_rxd)
         begin
            line_high_ff <= 1'b1;
         end
         else if (rx_done & brk_det)
         begin
            line_high_ff <= 1'b0;
         end
         if (rx_state_ff != RX_IDLE || !ctrl_ff.rx_enable || (tick && !i_rxd))
         begin
            idle_cnt_ff <= 8'h00;
         end
         else if (tick && idle_cnt_ff != idle_len)
         begin
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
         end
         if (tick)
         begin
            rx_phase_ff <= rx_phase_ff + 4'h1;
            if (rx_phase_ff == SAMPLE_A || rx_phase_ff == SAMPLE_B)
            begin
               rx_samp_ff <= {rx_samp_ff[0], i_rxd};
            end
         end
         case (rx_state_ff)
            RX_IDLE:
            begin
               if (start)
               begin
                  rx_state_ff <= RX_START;
                  rx_phase_ff <= 4'h1;
                  rx_noise_ff <= 1'b0;
                  rx_one_ff   <= 1'b0;
               end
            end
            RX_START:
            begin
               if (decide)
               begin
                  rx_state_ff <= bit_val ? RX_IDLE : RX_DATA;
                  rx_cnt_ff   <= 4'h0;
                  rx_noise_ff <= bit_nz;
               end
            end
            RX_DATA, RX_STOP, RX_LIN:
            begin
               if (decide)
               begin
                  rx_noise_ff <= rx_noise_ff | bit_nz;
                  if (rx_state_ff == RX_DATA)
                  begin
                     rx_shift_ff <= {bit_val, rx_shift_ff[8:1]};
                     rx_one_ff   <= rx_one_ff | bit_val;
                     rx_cnt_ff   <= rx_cnt_ff + 4'h1;
                     if (rx_cnt_ff == data_lst)
                     begin
                        rx_state_ff <= RX_STOP;
                     end
                  end
                  else if (rx_done)
                  begin
                     rx_state_ff <= RX_IDLE;
                  end
                  else
                  begin
                     rx_state_ff <= RX_LIN;
                  end
               end
            end
            default:
            begin
               rx_state_ff <= RX_IDLE;
            end
         endcase
         if (!ctrl_ff.rx_enable)
         begin
            rx_state_ff <= RX_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transmitter
   asbd_tx_state_t tx_state_ff;
   logic [3:0]  tx_phase_ff;
   logic [3:0]  tx_cnt_ff;
   logic [10:0] tx_shift_ff;
   logic        tx_en_d_ff;

   wire [3:0] frame_len = nine ? FRAME_BITS_9 : FRAME_BITS_8;
   wire       bit_end   = tick & (tx_phase_ff == TICK_LAST);
   wire       last_bit  = bit_end & (tx_cnt_ff == frame_len - 4'h1);
   wire       tx_rise   = ctrl_ff.tx_enable & ~tx_en_d_ff;
   wire       tx_load   = (tx_state_ff == TX_IDLE) & ~tx_rise & ~ctrl_ff.send_break
                          & ctrl_ff.tx_enable & ~stat_ff.tx_empty_flag;
   wire       par7      = ^tx_buf_ff[6:0] ^ ctrl_ff.parity_odd;
   wire       par8      = ^tx_buf_ff ^ ctrl_ff.parity_odd;
   wire       bit7      = ctrl_ff.parity_enable & ~nine ? par7 : tx_buf_ff[7];
   wire       bit8      = nine ? (ctrl_ff.parity_enable ? par8 : ctrl_ff.tx_ninth_bit) : 1'b1;
   wire [10:0] frame    = {1'b1, bit8, bit7, tx_buf_ff[6:0], 1'b0};

   asbd_tx_state_t nxt_tx_state;
   assign nxt_tx_state = (tx_state_ff == TX_IDLE) ?
                            (tx_rise ? TX_PRE :
                             (ctrl_ff.send_break & ctrl_ff.tx_enable) ? TX_BRK :
                             tx_load ? TX_FRAME : TX_IDLE) :
                         (last_bit & ~(tx_state_ff == TX_BRK & ctrl_ff.send_break)) ? TX_IDLE :
                         tx_state_ff;
   wire nxt_txd = (nxt_tx_state == TX_BRK) ? 1'b0 :
                  (nxt_tx_state == TX_FRAME) ? (tx_load ? 1'b0 : (bit_end ? tx_shift_ff[1] : tx_shift_ff[0])) :
                  1'b1;

   // bit timing restarts on queueing, so the line moves within one clock
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         tx_state_ff <= TX_IDLE;
         tx_phase_ff <= 4'h0;
         tx_cnt_ff   <= 4'h0;
         tx_shift_ff <= 11'h7FF;
         tx_en_d_ff  <= 1'b0;
         o_txd       <= 1'b1;
      end
      else
      begin
         tx_en_d_ff  <= ctrl_ff.tx_enable;
         tx_state_ff <= nxt_tx_state;
         o_txd       <= nxt_txd;
         if (tx_state_ff == TX_IDLE)
         begin
            tx_phase_ff <= 4'h0;
            tx_cnt_ff   <= 4'h0;
            tx_shift_ff <= frame;
         end
         else
         begin
            if (tick)
            begin
               tx_phase_ff <= tx_phase_ff + 4'h1;
            end
            if (last_bit)
            begin
               tx_cnt_ff <= 4'h0;
            end
            else if (bit_end)
            begin
               tx_cnt_ff   <= tx_cnt_ff + 4'h1;
               tx_shift_ff <= {1'b1, tx_shift_ff[10:1]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // status flags: a set in the same cycle beats the clear
   asbd_stat_t nxt_stat;
   wire nxt_te = tx_load | (stat_ff.tx_empty_flag & ~te_clr);
   assign nxt_stat.tx_empty_flag      = nxt_te;
   assign nxt_stat.transmit_done_flag = nxt_te & (nxt_tx_state == TX_IDLE);
   assign nxt_stat.rx_full_flag       = rx_take | (stat_ff.rx_full_flag & ~rx_clr[5]);
   assign nxt_stat.idle_flag          = (idle_hit & idle_arm_ff) | (stat_ff.idle_flag & ~rx_clr[4]);
   assign nxt_stat.overrun_flag       = (rx_done & ~rx_take) | (stat_ff.overrun_flag & ~rx_clr[3]);
   assign nxt_stat.noise_flag         = (rx_take & rx_noise_ff) | (stat_ff.noise_flag & ~rx_clr[2]);
   assign nxt_stat.framing_error_flag = (rx_take & fe_det) | (stat_ff.framing_error_flag & ~rx_clr[1]);
   assign nxt_stat.parity_error_flag  = (rx_take & ~brk_det & par_bad) | (stat_ff.parity_error_flag & ~rx_clr[0]);

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         stat_ff     <= STAT_RESET;
         bkf_ff      <= 1'b0;
         rpf_ff      <= 1'b0;
         idle_arm_ff <= 1'b0;
         o_tx_irq    <= 1'b0;
         o_rx_irq    <= 1'b0;
         o_err_irq   <= 1'b0;
      end
      else
      begin
         stat_ff <= nxt_stat;
         bkf_ff  <= (rx_take & brk_det) | (bkf_ff & ~bk_clr);
         if (start & (rx_state_ff == RX_IDLE))
         begin
            rpf_ff <= 1'b1;
         end
         else if ((decide & (rx_state_ff == RX_START) & bit_val) | idle_hit | rx_done)
         begin
            rpf_ff <= 1'b0;
         end
         if (!ctrl_ff.rx_enable | (idle_hit & idle_arm_ff) | rx_clr[4])
         begin
            idle_arm_ff <= 1'b0;
         end
         if (rx_take & ~brk_det)
         begin
            idle_arm_ff <= 1'b1;
         end
         o_tx_irq  <= (nxt_stat.tx_empty_flag & ien_ff.tx_empty_irq_enable)
                    | (nxt_stat.transmit_done_flag & ien_ff.transmit_done_irq_enable);
         o_rx_irq  <= nxt_stat.rx_full_flag & ien_ff.rx_full_irq_enable;
         o_err_irq <= (nxt_stat.idle_flag & ien_ff.idle_line_irq_enable)
                    | (nxt_stat.overrun_flag & ien_ff.overrun_irq_enable)
                    | (nxt_stat.noise_flag & ien_ff.noise_irq_enable)
                    | (nxt_stat.framing_error_flag & ien_ff.framing_irq_enable)
                    | (nxt_stat.parity_error_flag & ien_ff.parity_irq_enable);
      end
   end

endmodule // asbd_top

// file: verif/asbd_asserts.sv
// port-level assertion checker for the serial status block
module asbd_asserts
   import asbd_pkg::*;
(
   // clock, reset and apb
   input wire logic        i_clock,
   input wire logic        i_reset_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // serial output
   input wire logic        o_txd
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   logic w_map;
   logic w_rd;
   assign w_map = i_paddr inside {OFS_STATUS_ONE, OFS_STATUS_TWO, OFS_DATA, OFS_BAUD, OFS_CTRL, OFS_IRQ_EN};
   assign w_rd  = o_pready && !i_pwrite;
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   sequence s_access;
      i_psel && i_penable && o_pready;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> s_access) else $error("no ready after setup");
   a_ready_one_cycle: assert property (o_pready |=> !o_pready) else $error("ready held too long");
   a_ready_has_setup: assert property (o_pready |-> $past(i_psel && !i_penable)) else $error("stray ready");
   a_unmapped_err: assert property (o_pready |-> o_pslverr == !w_map) else $error("slave error wrong");
   a_write_no_data: assert property (o_pready && i_pwrite |-> o_prdata == 0) else $error("data on write");
   a_upper_bits_zero: assert property (o_pready |-> o_prdata[31:8] == 0) else $error("upper bits set");
   a_status_two_rsvd: assert property (w_rd && i_paddr == OFS_STATUS_TWO |-> o_prdata[7:2] == 0)
      else $error("status two reserved bits");
   a_baud_rsvd: assert property (w_rd && i_paddr == OFS_BAUD |-> !o_prdata[7] && !o_prdata[3])
      else $error("baud reserved bits");
   a_done_line_idle: assert property (w_rd && i_paddr == OFS_STATUS_ONE && o_prdata[6] |-> o_txd)
      else $error("line busy while done");
   a_start_bit_len: assert property ($fell(o_txd) |-> !o_txd [*8]) else $error("start bit too short");
endmodule // asbd_asserts
bind asbd_top asbd_asserts asbd_asserts_i (.i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
   .o_prdata, .o_pready, .o_pslverr, .o_txd);

// file: verif/asbd_node.sv
// remote serial node: drives the receive line, decodes the transmit line
module asbd_node
(
   input  wire logic i_clock,
   input  wire logic i_txd,
   output logic      o_rxd
);
   timeunit 1ns;
   timeprecision 100ps;
   // line rests high between frames
   initial o_rxd = 1'b1;
   // a zero stop bit makes a framing fault or, with zero data, a break
   task automatic send_byte(input logic [7:0] d, input logic stop, input int bclk);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         o_rxd <= f[i];
         repeat (bclk) @(posedge i_clock);
      end
      o_rxd <= 1'b1;
   endtask
   // bit time measured on bit 0: the start bit may run short by part of a tick
   // limitation: the byte must begin with a one followed by a zero
   task automatic get_byte(output int w, output logic [7:0] d);
      int s;
      for (int n = 0; n < 20000 && i_txd !== 1'b0; n++) @(posedge i_clock);
      for (s = 0; i_txd === 1'b0 && s < 5000; s++) @(posedge i_clock);
      for (w = 0; i_txd === 1'b1 && w < 5000; w++) @(posedge i_clock);
      d[0] = (w > 0);
      repeat (w / 2) @(posedge i_clock);
      for (int i = 1; i < 8; i++)
      begin
         d[i] = i_txd;
         repeat (w) @(posedge i_clock);
      end
   endtask
endmodule // asbd_node

// file: verif/tb.sv
// testbench: apb register traffic against a remote serial node
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import asbd_pkg::*;
   logic        i_clock, i_reset_n, i_psel, i_penable, i_pwrite, i_rxd;
   logic [7:0]  i_paddr, d;
   logic [31:0] i_pwdata, q;
   logic [31:0] o_prdata;
   logic        o_pready, o_pslverr, o_txd, o_tx_irq, o_rx_irq, o_err_irq;
   int          n_fail, num_checks, w;
   asbd_top asbd_top_i (.i_clock, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .i_rxd, .o_txd, .o_tx_irq, .o_rx_irq, .o_err_irq);
   asbd_node asbd_node_i (.i_clock, .i_txd(o_txd), .o_rxd(i_rxd));
   ////////////////////////////////////////
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // pre-edge values are read at the edge that ends the access
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge i_clock);
      i_psel <= 1'b1;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_clock);
      i_penable <= 1'b1;
      for (n = 0; n < 16 && o_pready !== 1'b1; n++) @(posedge i_clock);
      q = o_prdata;
      if (n == 16) chk(32'h0, 32'h1);
      if (n == 16) complete_run();
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h0);
      chk(q & m, exp);
   endtask
   // status polling is bounded; a hang ends the run
   task automatic poll(input logic [7:0] a, input logic [31:0] m);
      for (int n = 0; n < 3000; n++)
      begin
         apb(1'b0, a, 32'h0);
         if ((q & m) !== 32'h0) return;
      end
      chk(32'h0, m);
      complete_run();
   endtask
   ////////////////////////////////////////
   initial
   begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end
   initial
   begin
      repeat (60000) @(posedge i_clock);
      chk(32'h0, 32'h1);
      complete_run();
   end
   initial
   begin
      {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_reset_n} = '0;
      repeat (5) @(posedge i_clock);
      i_reset_n <= 1'b1;
      rd(OFS_STATUS_ONE, 32'hC0, 32'hFF);
      rd(OFS_STATUS_TWO, 32'h00, 32'h03);
      rd(OFS_BAUD, 32'h00, 32'hFF);
      rd(8'h3C, 32'h00, 32'hFF);
      apb(1'b1, OFS_BAUD, 32'hFF);
      rd(OFS_BAUD, 32'h77, 32'hFF);
      apb(1'b1, OFS_BAUD, 32'h00);
      apb(1'b1, OFS_IRQ_EN, 32'hA8);
      apb(1'b1, OFS_CTRL, 32'h02);
      asbd_node_i.send_byte(8'hA5, 1'b1, 16);
      poll(OFS_STATUS_ONE, 32'h20);
      chk(32'(o_rx_irq), 32'h1);
      rd(OFS_DATA, 32'hA5, 32'hFF);
      rd(OFS_STATUS_ONE, 32'h00, 32'h28);
      chk(32'(o_rx_irq), 32'h0);
      asbd_node_i.send_byte(8'h3C, 1'b1, 16);
      asbd_node_i.send_byte(8'hC3, 1'b1, 16);
      poll(OFS_STATUS_ONE, 32'h08);
      chk(32'(o_err_irq), 32'h1);
      rd(OFS_DATA, 32'h3C, 32'hFF);
      rd(OFS_STATUS_ONE, 32'h00, 32'h28);
      chk(32'(o_err_irq), 32'h0);
      poll(OFS_STATUS_ONE, 32'h10);
      rd(OFS_DATA, 32'h3C, 32'hFF);
      repeat (400) @(posedge i_clock);
      rd(OFS_STATUS_ONE, 32'h00, 32'h10);
      asbd_node_i.send_byte(8'h00, 1'b0, 16);
      poll(OFS_STATUS_ONE, 32'h02);
      chk(q & 32'h22, 32'h22);
      rd(OFS_STATUS_TWO, 32'h02, 32'h02);
      rd(OFS_DATA, 32'h00, 32'hFF);
      rd(OFS_STATUS_TWO, 32'h00, 32'h02);
      apb(1'b1, OFS_BAUD, 32'h11);
      apb(1'b1, OFS_CTRL, 32'h03);
      rd(OFS_STATUS_ONE, 32'h80, 32'h80);
      apb(1'b1, OFS_DATA, 32'h55);
      rd(OFS_STATUS_ONE, 32'h00, 32'hC0);
      asbd_node_i.get_byte(w, d);
      chk(32'(w), 32'd96);
      chk({24'h0, d}, 32'h55);
      chk(32'(o_tx_irq), 32'h1);
      poll(OFS_STATUS_ONE, 32'h40);
      complete_run();
   end
endmodule // tb
